// [logic/rmc_pkg.sv]
package rmc_pkg;
  // Clock and mode-switch timing.
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SWITCH_TIME_NS = 1000000;
  localparam int RELOAD_TIME_NS = 1000000;
  localparam int SWITCH_CYC     = SWITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int RELOAD_CYC     = (RELOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 16;
  // Data path geometry.
  localparam int DATA_W         = 8;
  localparam int FIFO_DEPTH     = 16;
  // Mode codes as {high, low} select pins.
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_WOR    = 2'h1;
  localparam logic [1:0] MODE_CONFIG = 2'h2;
  localparam logic [1:0] MODE_SLEEP  = 2'h3;
  // Header byte that opens a remote configuration frame.
  localparam logic [7:0] REMOTE_HDR  = 8'hCF;
  localparam logic [1:0] REMOTE_HDR_N = 2'h2;
  typedef enum logic [1:0] {ST_RELOAD, ST_RUN, ST_SWITCH} rmc_state_t;
endpackage

// [logic/rmc_fifo.sv]
`timescale 1ns/10ps
module rmc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths that the wrapping pointers cannot serve.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : badDepth
    $error("rmc_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } rmc_fifo_st_t;

  rmc_fifo_st_t s_q;
  rmc_fifo_st_t s_d;
  logic         push;
  logic         pop;

  // Ready comes from a flop; valid follows the stored count.
  assign inReady  = s_q.rdy;
  assign outValid = s_q.cnt != '0;
  assign outData  = s_q.mem[s_q.rd];
  assign push     = inValid && s_q.rdy;
  assign pop      = outValid && outReady;

  // Next state: write at the tail, read at the head, track the fill level.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = inData;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_d.rdy = s_d.cnt != (AW+1)'(DEPTH);
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [logic/rmc_mode_ctrl.sv]
`timescale 1ns/10ps
module rmc_mode_ctrl #(
  parameter int SWITCH_CYC = rmc_pkg::SWITCH_CYC,
  parameter int RELOAD_CYC = rmc_pkg::RELOAD_CYC,
  parameter int FIFO_DEPTH = rmc_pkg::FIFO_DEPTH
) (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      modeSelectHigh,
  input  wire logic                      modeSelectLow,
  input  wire logic                      worSender,
  input  wire logic [15:0]               worPeriod,
  input  wire logic                      remoteCfgDone,
  input  wire logic                      serRxValid,
  input  wire logic [rmc_pkg::DATA_W-1:0] serRxData,
  output logic                           serRxReady,
  output logic                           serTxValid,
  output logic [rmc_pkg::DATA_W-1:0]     serTxData,
  input  wire logic                      serTxReady,
  output logic                           radioTxValid,
  output logic [rmc_pkg::DATA_W-1:0]     radioTxData,
  input  wire logic                      radioTxReady,
  input  wire logic                      radioTxBusy,
  output logic                           wakeCode,
  input  wire logic                      radioRxValid,
  input  wire logic [rmc_pkg::DATA_W-1:0] radioRxData,
  output logic                           radioRxEnable,
  output logic                           cfgRxValid,
  output logic [rmc_pkg::DATA_W-1:0]     cfgRxData,
  output logic                           remoteCfgActive,
  output logic                           sleepActive,
  output logic                           auxReady,
  output logic [1:0]                     modeActive
);
  localparam int DW = rmc_pkg::DATA_W;

  // Refuse timings the 16-bit counter cannot hold.
  if (SWITCH_CYC < 1 || SWITCH_CYC >= (1 << rmc_pkg::CNT_W) ||
      RELOAD_CYC < 1 || RELOAD_CYC >= (1 << rmc_pkg::CNT_W)) begin : badTiming
    $error("rmc_mode_ctrl timing counts out of range");
  end

  typedef struct packed {
    logic [1:0]                pinMeta;
    logic [1:0]                pinSync;
    rmc_pkg::rmc_state_t       st;
    logic [rmc_pkg::CNT_W-1:0] cnt;
    logic [1:0]                mode;
    logic                      aux;
    logic                      sleep;
    logic                      rxEn;
    logic                      serRdy;
    logic                      txValid;
    logic [DW-1:0]             txData;
    logic                      txActive;
    logic                      wake;
    logic [15:0]               wakeCnt;
    logic                      sValid;
    logic [DW-1:0]             sData;
    logic                      cValid;
    logic [DW-1:0]             cData;
    logic [1:0]                hdrCnt;
    logic                      remote;
  } rmc_st_t;

  rmc_st_t s_q;
  rmc_st_t s_d;

  logic          fifoInValid;
  logic          fifoInReady;
  logic          fifoOutValid;
  logic [DW-1:0] fifoOutData;
  logic          fifoOutReady;
  logic          busy;
  logic          dataMode;
  logic          radioRxTake;

  // Serial bytes queue toward the radio; the radio side drains it.
  rmc_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .clk      (core_clk),
    .arst_n   (arst_n),
    .inValid  (fifoInValid),
    .inData   (serRxData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoOutReady)
  );

  // Data modes pass serial to radio; configuration bytes take the other branch.
  assign dataMode     = s_q.mode == rmc_pkg::MODE_NORMAL || s_q.mode == rmc_pkg::MODE_WOR;
  assign fifoInValid  = serRxValid && s_q.serRdy && dataMode;
  assign fifoOutReady = !s_q.txValid && !s_q.wake && s_q.txActive;
  assign radioRxTake  = radioRxValid && s_q.rxEn && !s_q.sValid;
  // Any queued, in-flight, outgoing or just arriving byte keeps the block busy.
  assign busy = fifoOutValid || s_q.txValid || s_q.txActive || radioTxBusy || s_q.wake ||
                s_q.sValid || s_q.cValid || (serRxValid && s_q.serRdy) ||
                radioRxTake;

  // Next state of the whole controller.
  always_comb begin
    s_d = s_q;
    s_d.pinMeta = {modeSelectHigh, modeSelectLow};
    s_d.pinSync = s_q.pinMeta;
    // Serial-to-radio sender, with the wake preamble for wake senders.
    if (s_q.txValid && radioTxReady) begin
      s_d.txValid = 1'b0;
    end
    if (!s_q.txActive && fifoOutValid) begin
      s_d.txActive = 1'b1;
      if (s_q.mode == rmc_pkg::MODE_WOR && worSender && worPeriod != 16'h0000) begin
        s_d.wake    = 1'b1;
        s_d.wakeCnt = worPeriod;
      end
    end else if (s_q.wake) begin
      s_d.wakeCnt = s_q.wakeCnt - 16'h0001;
      s_d.wake    = s_q.wakeCnt != 16'h0001;
    end else if (fifoOutValid && fifoOutReady) begin
      s_d.txValid = 1'b1;
      s_d.txData  = fifoOutData;
    end else if (s_q.txActive && !fifoOutValid && !s_q.txValid && !radioTxBusy) begin
      s_d.txActive = 1'b0;
    end
    // Radio-to-serial path, shared by normal and wake modes.
    if (s_q.sValid && serTxReady) begin
      s_d.sValid = 1'b0;
    end
    if (radioRxTake) begin
      s_d.sValid = 1'b1;
      s_d.sData  = radioRxData;
      if (s_q.mode == rmc_pkg::MODE_NORMAL && radioRxData == rmc_pkg::REMOTE_HDR) begin
        s_d.hdrCnt = (s_q.hdrCnt == rmc_pkg::REMOTE_HDR_N) ? s_q.hdrCnt :
                     s_q.hdrCnt + 2'h1;
      end else begin
        s_d.hdrCnt = 2'h0;
      end
    end
    // Remote configuration flag; a new header wins over the done strobe.
    if (remoteCfgDone) begin
      s_d.remote = 1'b0;
    end
    if (radioRxTake && s_d.hdrCnt == rmc_pkg::REMOTE_HDR_N) begin
      s_d.remote = 1'b1;
    end
    // Configuration mode hands serial bytes to the register logic.
    if (s_q.cValid) begin
      s_d.cValid = 1'b0;
    end
    if (serRxValid && s_q.serRdy && s_q.mode == rmc_pkg::MODE_CONFIG) begin
      s_d.cValid = 1'b1;
      s_d.cData  = serRxData;
    end
    // Mode sequencing.
    case (s_q.st)
      rmc_pkg::ST_RELOAD: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (s_q.cnt == '0) begin
          s_d.st = rmc_pkg::ST_RUN;
        end
      end
      rmc_pkg::ST_RUN: begin
        if (!busy && s_q.pinSync != s_q.mode) begin
          s_d.st  = rmc_pkg::ST_SWITCH;
          s_d.cnt = rmc_pkg::CNT_W'(SWITCH_CYC - 1);
        end
      end
      rmc_pkg::ST_SWITCH: begin
        s_d.cnt = s_q.cnt - 1'b1;
        if (busy) begin
          s_d.st = rmc_pkg::ST_RUN;
        end else if (s_q.cnt == '0) begin
          s_d.mode = s_q.pinSync;
          if (s_q.mode == rmc_pkg::MODE_SLEEP && s_q.pinSync != rmc_pkg::MODE_SLEEP) begin
            s_d.st  = rmc_pkg::ST_RELOAD;
            s_d.cnt = rmc_pkg::CNT_W'(RELOAD_CYC - 1);
          end else begin
            s_d.st = rmc_pkg::ST_RUN;
          end
        end
      end
      default: begin
        s_d.st = rmc_pkg::ST_RUN;
      end
    endcase
    // Registered outputs derived from the next state.
    s_d.sleep  = s_d.mode == rmc_pkg::MODE_SLEEP;
    s_d.rxEn   = (s_d.mode == rmc_pkg::MODE_NORMAL || s_d.mode == rmc_pkg::MODE_WOR ||
                  (s_d.mode == rmc_pkg::MODE_CONFIG && s_d.remote)) &&
                 s_d.st != rmc_pkg::ST_RELOAD;
    // Ready drops for one cycle after each byte accepted in a data mode, so the registered ready can
    // never promise room in a queue that filled on the same edge.
    s_d.serRdy = s_d.st == rmc_pkg::ST_RUN && s_d.mode != rmc_pkg::MODE_SLEEP &&
                 (s_d.mode == rmc_pkg::MODE_CONFIG || (fifoInReady && !fifoInValid));
    s_d.aux    = s_d.st != rmc_pkg::ST_RELOAD &&
                 !(fifoOutValid || fifoInValid || s_d.txValid || s_d.txActive || radioTxBusy ||
                   s_d.wake || s_d.sValid || s_d.cValid);
  end

  // State register; reset starts with a parameter load in normal mode.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q     <= '0;
      s_q.st  <= rmc_pkg::ST_RELOAD;
      s_q.cnt <= rmc_pkg::CNT_W'(RELOAD_CYC - 1);
    end else begin
      s_q <= s_d;
    end
  end

  assign serRxReady      = s_q.serRdy;
  assign serTxValid      = s_q.sValid;
  assign serTxData       = s_q.sData;
  assign radioTxValid    = s_q.txValid;
  assign radioTxData     = s_q.txData;
  assign wakeCode        = s_q.wake;
  assign radioRxEnable   = s_q.rxEn;
  assign cfgRxValid      = s_q.cValid;
  assign cfgRxData       = s_q.cData;
  assign remoteCfgActive = s_q.remote;
  assign sleepActive     = s_q.sleep;
  assign auxReady        = s_q.aux;
  assign modeActive      = s_q.mode;

  // Helper: consecutive cycles spent in the switch wait.
  logic [rmc_pkg::CNT_W:0] swAge;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      swAge <= '0;
    end else begin
      swAge <= (s_q.st == rmc_pkg::ST_SWITCH) ? swAge + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Mode sequencing checks.
  modeApply_a: assert property (
    s_q.st == rmc_pkg::ST_SWITCH && s_q.cnt == '0 && !busy |=> s_q.mode == $past(s_q.pinSync))
    else $error("mode not taken from pins");
  modeReady_a: assert property (
    s_q.mode != $past(s_q.mode) |-> $past(s_q.aux))
    else $error("mode changed while busy");
  switchTime_a: assert property (
    swAge <= (rmc_pkg::CNT_W+1)'(SWITCH_CYC))
    else $error("mode switch took too long");
  switchTxIdle_a: assert property (
    s_q.st == rmc_pkg::ST_SWITCH |-> !fifoOutValid && !s_q.txValid)
    else $error("switch with radio data pending");
  switchSerIdle_a: assert property (
    s_q.st == rmc_pkg::ST_SWITCH |-> !s_q.sValid)
    else $error("switch with serial data pending");
  sleepPin_a: assert property (
    $changed(s_q.mode) && s_q.mode == rmc_pkg::MODE_SLEEP |-> s_q.sleep)
    else $error("sleep not entered");
  sleepQuiet_a: assert property (
    s_q.mode == rmc_pkg::MODE_SLEEP |-> !s_q.serRdy && !s_q.rxEn)
    else $error("serial or radio open in sleep");
  reloadBusy_a: assert property (
    $past(s_q.mode) == rmc_pkg::MODE_SLEEP && s_q.mode != rmc_pkg::MODE_SLEEP |-> !s_q.aux [*2])
    else $error("ready high during reload");
  cfgRadioOff_a: assert property (
    s_q.mode == rmc_pkg::MODE_CONFIG && !s_q.remote |-> !s_q.rxEn)
    else $error("radio on in configuration mode");
  // Data path checks.
  wakeFirst_a: assert property (
    $rose(s_q.wake) |-> !s_q.txValid throughout (s_q.wake [*1]))
    else $error("data sent during wake code");
  fifoToRadio_a: assert property (
    fifoOutValid && fifoOutReady |=> s_q.txValid && s_q.txData == $past(fifoOutData))
    else $error("queued byte not sent");
  pushTaken_a: assert property (
    fifoInValid |-> fifoInReady)
    else $error("host byte acknowledged but not queued");

  sleepEntry_c: cover property (s_q.mode == rmc_pkg::MODE_NORMAL ##1 s_q.mode == rmc_pkg::MODE_SLEEP);
  reloadExit_c: cover property (s_q.mode == rmc_pkg::MODE_SLEEP ##1 s_q.st == rmc_pkg::ST_RELOAD);
  wakeSend_c: cover property ($fell(s_q.wake) ##[1:4] s_q.txValid);
  remoteCfg_c: cover property ($rose(s_q.remote));
endmodule

// [dv/rmc_radio_model.sv]
`timescale 1ns/10ps
module rmc_radio_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       radioTxValid,
  input  wire logic [7:0] radioTxData,
  output logic            radioTxReady,
  output logic            radioTxBusy,
  input  wire logic       radioRxEnable,
  output logic            radioRxValid,
  output logic [7:0]      radioRxData
);
  logic       stall = 1'b0;
  logic [7:0] airQ[$];
  int         busyCnt = 0;
  // Each accepted byte keeps the air busy for a few cycles, as a real modem would.
  always @(posedge core_clk) begin
    if (radioTxValid && radioTxReady) begin
      airQ.push_back(radioTxData);
      busyCnt <= 4;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end
  end
  // The testbench may stall the modem to keep bytes pending.
  assign radioTxReady = arst_n && !stall;
  assign radioTxBusy  = (busyCnt != 0);
  initial begin
    radioRxValid = 1'b0;
    radioRxData  = 8'h00;
  end
  // A received byte is offered for one cycle; then the bus shows its inverse for one
  // more cycle so that the serial side drains before the next byte arrives.
  task automatic air_rx(input logic [7:0] b);
    radioRxValid = 1'b1;
    radioRxData  = b;
    @(posedge core_clk);
    #1;
    radioRxValid = 1'b0;
    radioRxData  = ~b;
    @(posedge core_clk);
    #1;
  endtask
endmodule

// [dv/radio_module_mode_controller_tb_top.sv]
`timescale 1ns/10ps
module radio_module_mode_controller_tb_top;
  localparam int SW = 20;
  localparam int RL = 10;
  logic core_clk, arst_n, modeSelectHigh, modeSelectLow, worSender, remoteCfgDone;
  logic serRxValid, serRxReady, serTxValid, serTxReady, radioTxValid, radioTxReady;
  logic radioTxBusy, wakeCode, radioRxValid, radioRxEnable, cfgRxValid, remoteCfgActive;
  logic sleepActive, auxReady, seenCfg;
  logic [15:0] worPeriod;
  logic [7:0]  serRxData, serTxData, radioTxData, radioRxData, cfgRxData;
  logic [1:0]  modeActive;
  logic [7:0]  serQ[$];
  logic [7:0]  cfgQ[$];
  int          bad_count = 0;
  int          checks = 0;

  rmc_mode_ctrl #(.SWITCH_CYC(SW), .RELOAD_CYC(RL), .FIFO_DEPTH(16)) dut (.core_clk(core_clk),
    .arst_n(arst_n), .modeSelectHigh(modeSelectHigh), .modeSelectLow(modeSelectLow),
    .worSender(worSender), .worPeriod(worPeriod), .remoteCfgDone(remoteCfgDone),
    .serRxValid(serRxValid), .serRxData(serRxData), .serRxReady(serRxReady),
    .serTxValid(serTxValid), .serTxData(serTxData), .serTxReady(serTxReady),
    .radioTxValid(radioTxValid), .radioTxData(radioTxData), .radioTxReady(radioTxReady),
    .radioTxBusy(radioTxBusy), .wakeCode(wakeCode), .radioRxValid(radioRxValid),
    .radioRxData(radioRxData), .radioRxEnable(radioRxEnable), .cfgRxValid(cfgRxValid),
    .cfgRxData(cfgRxData), .remoteCfgActive(remoteCfgActive), .sleepActive(sleepActive),
    .auxReady(auxReady), .modeActive(modeActive));
  rmc_radio_model radio (.core_clk(core_clk), .arst_n(arst_n), .radioTxValid(radioTxValid),
    .radioTxData(radioTxData), .radioTxReady(radioTxReady), .radioTxBusy(radioTxBusy),
    .radioRxEnable(radioRxEnable), .radioRxValid(radioRxValid), .radioRxData(radioRxData));

  // The clock toggles every half period of 100 ns.
  always #50 core_clk = ~core_clk;
  // The host UART sink and the register port are recorded as they hand bytes over.
  always @(posedge core_clk) begin
    if (serTxValid === 1'b1 && serTxReady) serQ.push_back(serTxData);
    if (cfgRxValid === 1'b1) cfgQ.push_back(cfgRxData);
    if (modeActive === rmc_pkg::MODE_CONFIG) seenCfg = 1'b1;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Waits a bounded time for a mode to take effect and returns the cycles spent.
  task automatic wait_mode(input logic [1:0] m, input int lim, output int n);
    n = 0;
    while (modeActive !== m && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      check(1'b0, 1'b1, "mode wait timed out");
      report_and_stop();
    end
  endtask
  task automatic set_mode(input logic [1:0] m);
    int n;
    {modeSelectHigh, modeSelectLow} = m;
    wait_mode(m, SW + 40, n);
    check(n >= SW && n <= SW + 8, 1'b1, "switch delay");
    check(modeActive, m, "mode decode");
  endtask
  // Offers one host byte and holds it until taken; valid stays high on return.
  task automatic send_ser(input logic [7:0] b);
    int n;
    serRxValid = 1'b1;
    serRxData  = b;
    n = 0;
    while (serRxReady !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(n < 100, 1'b1, "serial byte not taken");
    tick(1);
  endtask

  task automatic t_remote();
    radio.air_rx(rmc_pkg::REMOTE_HDR);
    radio.air_rx(rmc_pkg::REMOTE_HDR);
    tick(3);
    check(remoteCfgActive, 1'b1, "remote header");
    check(serQ.size(), 2, "header forwarded");
    remoteCfgDone = 1'b1;
    tick(1);
    remoteCfgDone = 1'b0;
    tick(2);
    check(remoteCfgActive, 1'b0, "remote done");
    serQ.delete();
    $display("Remote configuration test done");
  endtask
  task automatic t_normal();
    send_ser(8'hA5);
    send_ser(8'h5A);
    serRxValid = 1'b0;
    tick(20);
    check(radio.airQ.size(), 2, "bytes sent");
    check({radio.airQ[0], radio.airQ[1]}, 16'hA55A, "byte order");
    serTxReady = 1'b0;
    radio.air_rx(8'h3C);
    tick(3);
    check(auxReady, 1'b0, "busy while serial out pending");
    serTxReady = 1'b1;
    tick(3);
    check({serQ.size(), serQ[0]}, 16'h013C, "radio byte out");
    serQ.delete();
    radio.airQ.delete();
    $display("Normal mode test done");
  endtask
  task automatic t_wake();
    int n;
    int w;
    set_mode(rmc_pkg::MODE_WOR);
    worSender = 1'b1;
    worPeriod = 16'h0005;
    send_ser(8'h77);
    serRxValid = 1'b0;
    n = 0;
    w = 0;
    while (radioTxValid !== 1'b1 && n < 50) begin
      if (wakeCode === 1'b1) w++;
      tick(1);
      n++;
    end
    check(w, 5, "wake code length");
    tick(3);
    check(radio.airQ[0], 8'h77, "data after wake");
    radio.air_rx(8'h42);
    tick(3);
    check({serQ.size(), serQ[0]}, 16'h0142, "wake mode receive");
    worSender = 1'b0;
    serQ.delete();
    radio.airQ.delete();
    $display("Wake mode test done");
  endtask
  task automatic t_config();
    set_mode(rmc_pkg::MODE_CONFIG);
    check(radioRxEnable, 1'b0, "radio off in config");
    send_ser(8'hC1);
    serRxValid = 1'b0;
    tick(3);
    check({cfgQ.size(), cfgQ[0]}, 16'h01C1, "register byte");
    check(radio.airQ.size(), 0, "no air traffic");
    radio.air_rx(8'h99);
    tick(3);
    check(serQ.size(), 0, "no reception in config");
    $display("Configuration mode test done");
  endtask
  task automatic t_pending();
    int acc;
    int n;
    set_mode(rmc_pkg::MODE_NORMAL);
    radio.stall = 1'b1;
    acc = 0;
    serRxValid = 1'b1;
    for (int i = 0; i < 40; i++) begin
      serRxData = acc[7:0];
      if (serRxReady === 1'b1) acc++;
      tick(1);
    end
    check(serRxReady, 1'b0, "full buffer refuses");
    serRxValid = 1'b0;
    check(acc >= 16 && acc <= 19, 1'b1, "buffer depth");
    check(auxReady, 1'b0, "busy with data pending");
    // The host switches without waiting for ready, first to config, then to sleep.
    {modeSelectHigh, modeSelectLow} = rmc_pkg::MODE_CONFIG;
    seenCfg = 1'b0;
    tick(5);
    {modeSelectHigh, modeSelectLow} = rmc_pkg::MODE_SLEEP;
    tick(SW + 20);
    check(modeActive, rmc_pkg::MODE_NORMAL, "switch postponed");
    radio.stall = 1'b0;
    wait_mode(rmc_pkg::MODE_SLEEP, SW + 150, n);
    check(radio.airQ.size(), acc, "all pending sent");
    for (int k = 0; k < acc; k++) check(radio.airQ[k], k, "pending order");
    check(seenCfg, 1'b0, "latest request applied");
    check({sleepActive, radioRxEnable, serRxReady}, 3'b100, "sleep state");
    check(n <= acc * 6 + SW + 10, 1'b1, "sleep after work");
    {modeSelectHigh, modeSelectLow} = rmc_pkg::MODE_NORMAL;
    wait_mode(rmc_pkg::MODE_NORMAL, SW + RL + 40, n);
    check(auxReady, 1'b0, "reload after sleep");
    n = 0;
    while (auxReady !== 1'b1 && n < RL + 20) begin
      tick(1);
      n++;
    end
    check(auxReady, 1'b1, "ready after reload");
    $display("Pending switch test done");
  endtask

  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {modeSelectHigh, modeSelectLow} = 2'h0;
    {worSender, remoteCfgDone, serRxValid, seenCfg} = 4'h0;
    worPeriod = 16'h0000;
    serRxData = 8'h00;
    serTxReady = 1'b1;
    tick(10);
    arst_n = 1'b1;
    check(auxReady, 1'b0, "busy during reload");
    tick(RL + 20);
    check({auxReady, radioRxEnable, modeActive}, 4'hC, "idle normal after reset");
    $display("Reset test done");
    t_remote();
    t_normal();
    t_wake();
    t_config();
    t_pending();
    report_and_stop();
  end
endmodule
